// file: common/udc_defines.svh
`ifndef UDC_DEFINES_SVH
`define UDC_DEFINES_SVH

// counter width and bcd limits
`define UDC_CNT_W        4
`define UDC_BCD_MIN      4'h0
`define UDC_BCD_MAX      4'h9
`define UDC_BCD_ONE      4'h1
`define UDC_RST_COUNT    4'h0

// synchroniser depth for every pin input
`define UDC_SYNC_STAGES  2

// layout of the pin bundle that crosses into the counter
`define UDC_PIN_W        9
`define UDC_PIN_CLK      0
`define UDC_PIN_CE_N     1
`define UDC_PIN_DIR      2
`define UDC_PIN_LOAD     3
`define UDC_PIN_CLEAR    4
`define UDC_PIN_PRE_LO   5
`define UDC_PIN_PRE_HI   8

// synchroniser contents while in reset: every pin at its idle level, enable off
`define UDC_PIN_RST      9'h002

`endif

// file: common/udc_pkg.sv
package udc_pkg;

   // what the counter does in a given cycle; priority runs clear, load, hold, then count
   typedef enum logic [2:0] {
      MODE_CLEAR,
      MODE_LOAD,
      MODE_COUNT,
      MODE_HOLD,
      MODE_IDLE
   } udc_mode_e;

   // counting direction as seen on the direction pin
   typedef enum logic {
      DIR_DOWN,
      DIR_UP
   } udc_dir_e;

   typedef logic [3:0] udc_bcd_t;

endpackage : udc_pkg

// file: common/udc_pin_if.sv
`timescale 1ns/1ns
`include "udc_defines.svh"

interface udc_pin_if;
   logic [`UDC_PIN_W-1:0] raw;
   logic [`UDC_PIN_W-1:0] synced;

   modport sync_side (
      input  raw,
      output synced
   );

   modport core_side (
      output raw,
      input  synced
   );
endinterface : udc_pin_if

// file: verilog/udc_sync.sv
`timescale 1ns/1ns
`include "udc_defines.svh"

module udc_sync #(
   parameter int WIDTH  = `UDC_PIN_W,
   parameter int STAGES = `UDC_SYNC_STAGES
) (
   input  wire logic     clk,
   input  wire logic     arst_n,
   input  wire logic     clk_en,
   udc_pin_if.sync_side  pins
);

   // idle pin levels, so no false enable or edge shows after reset
   localparam logic [WIDTH-1:0] RST_LVL = WIDTH'(`UDC_PIN_RST);

   // one chain of flops per pin bit; only the last stage is read
   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : g_bit
         logic [STAGES-1:0] chain_r;
         logic [STAGES-1:0] chain_nxt;

         // shift the pin level one stage per enabled cycle
         always_comb begin
            chain_nxt = chain_r;
            if (clk_en) begin
               chain_nxt = {chain_r[STAGES-2:0], pins.raw[b]};
            end
         end

         // register only
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               chain_r <= {STAGES{RST_LVL[b]}};
            end else begin
               chain_r <= chain_nxt;
            end
         end

         assign pins.synced[b] = chain_r[STAGES-1];
      end
   endgenerate

endmodule : udc_sync

// file: verilog/udc_counter.sv
`timescale 1ns/1ns
`include "udc_defines.svh"

module udc_counter #(
   parameter int CNT_W = `UDC_CNT_W
) (
   input  wire logic             SYS_CLK,
   input  wire logic             ARST_N,
   input  wire logic             CLK_EN,
   input  wire logic             COUNT_CLOCK,
   input  wire logic             COUNT_ENABLE_N,
   input  wire logic             COUNT_DIRECTION,
   input  wire logic             PARALLEL_LOAD,
   input  wire logic [CNT_W-1:0] PRESET_VALUE,
   input  wire logic             MASTER_CLEAR,
   output logic      [CNT_W-1:0] COUNT_VALUE,
   output logic                  TERMINAL_COUNT_N
);

   // pin bundle between the pads and the counting core
   udc_pin_if pins ();

   // gather every pin into one vector for the synchroniser
   assign pins.raw[`UDC_PIN_CLK]                        = COUNT_CLOCK;
   assign pins.raw[`UDC_PIN_CE_N]                       = COUNT_ENABLE_N;
   assign pins.raw[`UDC_PIN_DIR]                        = COUNT_DIRECTION;
   assign pins.raw[`UDC_PIN_LOAD]                       = PARALLEL_LOAD;
   assign pins.raw[`UDC_PIN_CLEAR]                      = MASTER_CLEAR;
   assign pins.raw[`UDC_PIN_PRE_HI:`UDC_PIN_PRE_LO]     = PRESET_VALUE;

   // two flops on every pin before any logic sees it
   udc_sync #(
      .WIDTH  (`UDC_PIN_W),
      .STAGES (`UDC_SYNC_STAGES)
   ) u_sync (
      .clk    (SYS_CLK),
      .arst_n (ARST_N),
      .clk_en (CLK_EN),
      .pins   (pins.sync_side)
   );

   // synchronised pin levels
   logic                  count_clock_s;
   logic                  count_enable_n_s;
   udc_pkg::udc_dir_e     count_direction_s;
   logic                  parallel_load_s;
   logic                  master_clear_s;
   logic [CNT_W-1:0]      preset_value_s;

   assign count_clock_s     = pins.synced[`UDC_PIN_CLK];
   assign count_enable_n_s  = pins.synced[`UDC_PIN_CE_N];
   assign count_direction_s = udc_pkg::udc_dir_e'(pins.synced[`UDC_PIN_DIR]);
   assign parallel_load_s   = pins.synced[`UDC_PIN_LOAD];
   assign master_clear_s    = pins.synced[`UDC_PIN_CLEAR];
   assign preset_value_s    = pins.synced[`UDC_PIN_PRE_HI:`UDC_PIN_PRE_LO];

   // state
   logic                  clk_prev_r;
   logic                  clk_prev_nxt;
   logic [CNT_W-1:0]      count_r;
   logic [CNT_W-1:0]      count_nxt;
   logic                  tc_n_r;
   logic                  tc_n_nxt;
   udc_pkg::udc_mode_e    mode_r;
   udc_pkg::udc_mode_e    mode_nxt;

   // combinational helpers
   logic                  clk_rise;
   logic [CNT_W-1:0]      count_step;

   // rising edge of the count clock, seen on the synchronised copy
   assign clk_rise = count_clock_s & ~clk_prev_r;

   // next bcd value in the selected direction, wrapping nine and zero
   function automatic logic [CNT_W-1:0] bcd_step(
      input logic [CNT_W-1:0] cur,
      input udc_pkg::udc_dir_e dir
   );
      logic [CNT_W-1:0] res;
      res = cur;
      if (dir == udc_pkg::DIR_UP) begin
         // codes above nine fall back to zero as well
         if (cur >= `UDC_BCD_MAX) begin
            res = `UDC_BCD_MIN;
         end else begin
            res = cur + `UDC_BCD_ONE;
         end
      end else begin
         if (cur == `UDC_BCD_MIN) begin
            res = `UDC_BCD_MAX;
         end else begin
            res = cur - `UDC_BCD_ONE;
         end
      end
      return res;
   endfunction : bcd_step

   assign count_step = bcd_step(count_r, count_direction_s);

   // pick this cycle's action: clear beats load beats counting
   always_comb begin
      mode_nxt = udc_pkg::MODE_IDLE;
      if (master_clear_s) begin
         mode_nxt = udc_pkg::MODE_CLEAR;
      end else if (parallel_load_s) begin
         mode_nxt = udc_pkg::MODE_LOAD;
      end else if (count_enable_n_s) begin
         mode_nxt = udc_pkg::MODE_HOLD;
      end else if (clk_rise) begin
         mode_nxt = udc_pkg::MODE_COUNT;
      end
   end

   // next count value from the chosen action
   always_comb begin
      count_nxt = count_r;
      case (mode_nxt)
         udc_pkg::MODE_CLEAR: begin
            count_nxt = `UDC_RST_COUNT;
         end
         udc_pkg::MODE_LOAD: begin
            count_nxt = preset_value_s;
         end
         udc_pkg::MODE_COUNT: begin
            count_nxt = count_step;
         end
         udc_pkg::MODE_HOLD: begin
            count_nxt = count_r;
         end
         default: begin
            count_nxt = count_r;
         end
      endcase
   end

   // terminal count follows the new count and the current control levels
   always_comb begin
      tc_n_nxt = 1'b1;
      if (!count_enable_n_s) begin
         if (count_direction_s == udc_pkg::DIR_UP) begin
            tc_n_nxt = (count_nxt != `UDC_BCD_MAX);
         end else begin
            tc_n_nxt = (count_nxt != `UDC_BCD_MIN);
         end
      end
   end

   // edge memory keeps tracking the pin even while loading or cleared,
   // so a clock left high during a load gives no spurious count after it
   always_comb begin
      clk_prev_nxt = count_clock_s;
   end

   // register only; everything freezes while the clock enable is low
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         count_r    <= `UDC_RST_COUNT;
         tc_n_r     <= 1'b1;
         clk_prev_r <= 1'b0;
         mode_r     <= udc_pkg::MODE_IDLE;
      end else if (CLK_EN) begin
         count_r    <= count_nxt;
         tc_n_r     <= tc_n_nxt;
         clk_prev_r <= clk_prev_nxt;
         mode_r     <= mode_nxt;
      end
   end

   // outputs straight from flops
   assign COUNT_VALUE      = count_r;
   assign TERMINAL_COUNT_N = tc_n_r;

endmodule : udc_counter

// file: test/udc_counter_monitor.sv
`timescale 1ns/1ns
module udc_counter_monitor #(
   parameter int CNT_W = 4
) (
   input wire logic             SYS_CLK,
   input wire logic             ARST_N,
   input wire logic             CLK_EN,
   input wire logic             COUNT_CLOCK,
   input wire logic             COUNT_ENABLE_N,
   input wire logic             COUNT_DIRECTION,
   input wire logic             PARALLEL_LOAD,
   input wire logic [CNT_W-1:0] PRESET_VALUE,
   input wire logic             MASTER_CLEAR,
   input wire logic [CNT_W-1:0] COUNT_VALUE,
   input wire logic             TERMINAL_COUNT_N
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   // counting may happen: no load, no clear, system clock enabled
   wire f = CLK_EN && !PARALLEL_LOAD && !MASTER_CLEAR;
   property p_clr; (CLK_EN && MASTER_CLEAR)[*3] |=> COUNT_VALUE == '0; endproperty
   a_clr: assert property (p_clr) else $error("clear missed");
   property p_ld; (CLK_EN && PARALLEL_LOAD && !MASTER_CLEAR && $stable(PRESET_VALUE))[*4]
      |=> COUNT_VALUE == $past(PRESET_VALUE); endproperty
   a_ld: assert property (p_ld) else $error("load missed");
   property p_tcu; (CLK_EN && COUNT_DIRECTION && !COUNT_ENABLE_N)[*4]
      |-> TERMINAL_COUNT_N == (COUNT_VALUE != 4'h9); endproperty
   a_tcu: assert property (p_tcu) else $error("terminal up wrong");
   property p_tcd; (CLK_EN && !COUNT_DIRECTION && !COUNT_ENABLE_N)[*4]
      |-> TERMINAL_COUNT_N == (COUNT_VALUE != 4'h0); endproperty
   a_tcd: assert property (p_tcd) else $error("terminal down wrong");
   property p_hold; (f && COUNT_ENABLE_N)[*4] |=> $stable(COUNT_VALUE) && TERMINAL_COUNT_N;
   endproperty
   a_hold: assert property (p_hold) else $error("count moved while disabled");
   property p_up; (f && COUNT_DIRECTION)[*5] ##1 $changed(COUNT_VALUE) |-> COUNT_VALUE ==
      ($past(COUNT_VALUE) >= 4'h9 ? 4'h0 : $past(COUNT_VALUE) + 4'h1); endproperty
   a_up: assert property (p_up) else $error("bad up step");
   property p_dn; (f && !COUNT_DIRECTION)[*5] ##1 $changed(COUNT_VALUE) |-> COUNT_VALUE ==
      ($past(COUNT_VALUE) == 4'h0 ? 4'h9 : $past(COUNT_VALUE) - 4'h1); endproperty
   a_dn: assert property (p_dn) else $error("bad down step");
   property p_rise; !COUNT_CLOCK && f ##1 (COUNT_CLOCK && !COUNT_ENABLE_N && f)[*3]
      |=> COUNT_VALUE != $past(COUNT_VALUE, 3); endproperty
   a_rise: assert property (p_rise) else $error("rise not counted");
   property p_frz; !CLK_EN |=> $stable(COUNT_VALUE) && $stable(TERMINAL_COUNT_N); endproperty
   a_frz: assert property (p_frz) else $error("state moved while frozen");
   c_frz: cover property (!CLK_EN ##1 CLK_EN);
   c_clr: cover property (MASTER_CLEAR && PARALLEL_LOAD);
   c_wrap: cover property (COUNT_VALUE == 4'h9 ##[1:60] COUNT_VALUE == 4'h0);
   c_tc: cover property ($fell(TERMINAL_COUNT_N));
endmodule : udc_counter_monitor

bind udc_counter udc_counter_monitor #(.CNT_W(CNT_W)) u_mon (.SYS_CLK(SYS_CLK),
   .ARST_N(ARST_N), .CLK_EN(CLK_EN), .COUNT_CLOCK(COUNT_CLOCK), .COUNT_ENABLE_N(COUNT_ENABLE_N),
   .COUNT_DIRECTION(COUNT_DIRECTION), .PARALLEL_LOAD(PARALLEL_LOAD), .PRESET_VALUE(PRESET_VALUE),
   .MASTER_CLEAR(MASTER_CLEAR), .COUNT_VALUE(COUNT_VALUE), .TERMINAL_COUNT_N(TERMINAL_COUNT_N));

// file: test/udc_ctl_model.sv
`timescale 1ns/1ns
// one count clock pulse per start: high for len cycles, then low for len cycles
module udc_ctl_model (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       start,
   input  wire logic [3:0] len,
   output logic            count_clock,
   output logic            busy
);
   logic [4:0] ph_r;
   // phase down-counter, idle at zero with the pin resting low
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) ph_r <= 5'h0;
      else if (busy) ph_r <= ph_r - 5'h1;
      else if (start) ph_r <= {len, 1'b0};
   end
   assign count_clock = ph_r > {1'b0, len};
   assign busy = ph_r != 5'h0;
endmodule : udc_ctl_model

// file: test/udc_counter_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module udc_counter_tb;
   logic       clk = 1'b0, arst_n = 1'b0, en_n = 1'b1, dir = 1'b1, load = 1'b0, clr = 1'b0;
   logic       start = 1'b0, ce = 1'b1, cclk, busy, tc_n;
   logic [3:0] pre = 4'h0, len = 4'h3, cnt, exp_cnt = 4'h0;
   logic [4:0] last = 5'h1, seen = 5'h1, note, want, q[$];
   int         fail_count = 0, samples_checked = 0, cycles = 0;
   udc_counter dut (.SYS_CLK(clk), .ARST_N(arst_n), .CLK_EN(ce), .COUNT_CLOCK(cclk),
      .COUNT_ENABLE_N(en_n), .COUNT_DIRECTION(dir), .PARALLEL_LOAD(load), .PRESET_VALUE(pre),
      .MASTER_CLEAR(clr), .COUNT_VALUE(cnt), .TERMINAL_COUNT_N(tc_n));
   udc_ctl_model ctl (.clk(clk), .arst_n(arst_n), .start(start), .len(len),
      .count_clock(cclk), .busy(busy));
   initial forever #5 clk = ~clk;
   task tally_and_finish();
      $display("checks %0d failures %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish
   // one partner pulse, quick or slow
   task pulse();
      len = 4'($urandom_range(8, 3));
      start = 1'b1;
      @(posedge clk) #1 start = 1'b0;
      while (busy) @(posedge clk);
   endtask : pulse
   // apply one operation and note the outputs it should leave
   task act(input int op, input logic [3:0] v);
      @(posedge clk) #1;
      case (op)
         0: if (!en_n) exp_cnt = dir ? (exp_cnt == 4'h9 ? 4'h0 : exp_cnt + 4'h1)
                                     : (exp_cnt == 4'h0 ? 4'h9 : exp_cnt - 4'h1);
         1: dir = !dir;
         2: en_n = !en_n;
         default: begin
            load = 1'b1;
            pre = v;
            clr = op[0];
            exp_cnt = clr ? 4'h0 : v;
         end
      endcase
      note = {exp_cnt, !(!en_n && exp_cnt == (dir ? 4'h9 : 4'h0))};
      if (note !== last) q.push_back(note);
      last = note;
      // freeze the block for two cycles while the new pin levels wait
      ce = 1'b0;
      repeat (2) @(posedge clk);
      #1 ce = 1'b1;
      if (op != 1 && op != 2) pulse();
      repeat (6) @(posedge clk);
      #1 load = 1'b0;
      clr = 1'b0;
      repeat (6) @(posedge clk);
   endtask : act
   // compare each output change against the oldest note
   always @(negedge clk) begin
      if (arst_n && {cnt, tc_n} !== seen) begin
         seen = {cnt, tc_n};
         want = q.size() ? q.pop_front() : 'x;
         `CHK(seen, want)
      end
   end
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   initial begin
      void'($urandom(32'hae5cee7e));
      repeat (3) @(posedge clk);
      #1 arst_n = 1'b1;
      act(2, 4'h0);
      act(4, 4'h9);
      act(0, 4'h0);
      act(1, 4'h0);
      act(0, 4'h0);
      act(3, 4'h5);
      repeat (60) act($urandom_range(4, 0), 4'($urandom_range(9, 0)));
      `CHK(q.size(), 0)
      tally_and_finish();
   end
endmodule : udc_counter_tb
